// ===== bench/lur_ctl_model.sv
// Behavioural frame engine on the controller side of the register bank
`timescale 1ns/1ps
module lur_ctl_model (
    input wire mclk_i, // Clock
    output logic busy_o, // Frame in progress
    output logic [2:0] id_status_o, // Identifier status
    output logic [6:0] err_evt_o, // Fault pulses
    output logic id_ok_o, // Identifier pulse
    output logic tx_ok_o, // Transmit done pulse
    output logic rx_ok_o, // Receive done pulse
    output logic par_we_o, // Parity load
    output logic [1:0] par_o, // Parity value
    output logic rx_we_o, // Received byte strobe
    output logic [2:0] rx_idx_o, // Received slot
    output logic [7:0] rx_data_o, // Received byte
    output logic [2:0] tx_idx_o // Slot being sent
);
    // Idle engine: no events, data lines carry junk rather than a stale copy
    initial begin
        {busy_o, id_status_o, err_evt_o, id_ok_o, tx_ok_o, rx_ok_o, par_we_o, rx_we_o} = 16'h0000;
        {par_o, rx_idx_o, rx_data_o, tx_idx_o} = 16'h5A5A;
    end
    // Event pulses last exactly one cycle
    task automatic pulse(input logic [6:0] e, input logic [2:0] k);
        @(posedge mclk_i);
        err_evt_o <= e;
        {id_ok_o, tx_ok_o, rx_ok_o} <= k;
        @(posedge mclk_i);
        err_evt_o <= 7'h00;
        {id_ok_o, tx_ok_o, rx_ok_o} <= 3'h0;
        #1;
    endtask
    task automatic state(input logic b, input logic [2:0] s, input logic [2:0] t);
        @(posedge mclk_i);
        busy_o <= b;
        id_status_o <= s;
        tx_idx_o <= t;
        #1;
    endtask
    // After the strobe the data lines are inverted so a stale value cannot pass
    task automatic rx_byte(input logic [2:0] i, input logic [7:0] d);
        @(posedge mclk_i);
        {rx_we_o, rx_idx_o, rx_data_o} <= {1'b1, i, d};
        @(posedge mclk_i);
        {rx_we_o, rx_idx_o, rx_data_o} <= {1'b0, ~i, ~d};
        #1;
    endtask
    task automatic parity(input logic [1:0] p);
        @(posedge mclk_i);
        {par_we_o, par_o} <= {1'b1, p};
        @(posedge mclk_i);
        {par_we_o, par_o} <= {1'b0, ~p};
        #1;
    endtask
endmodule // lur_ctl_model

// ===== bench/lur_regs_monitor.sv
// Port-level checks for the LIN/UART register bank
`timescale 1ns/1ps
`include "lur_defines.vh"
module lur_regs_monitor (
    input wire mclk_i, // Clock
    input wire rst_b_i, // Reset, active low
    input wire [3:0] addr_i, // Address
    input wire [7:0] wdata_i, // Write data
    input wire wr_i, // Write strobe
    input wire rd_i, // Read strobe
    input wire [7:0] rdata_o, // Read data
    input wire [7:0] tx_data_o, // Outgoing byte
    input wire uart_tx_start_o, // UART send pulse
    input wire lin13_o, // Legacy version
    input wire uart_mode_o, // UART mode
    input wire enable_o, // Enabled
    input wire resync_disable_o, // Resync off
    input wire [5:0] samples_per_bit_o, // Samples per bit
    input wire [11:0] baud_divisor_o, // Divider
    input wire sample_tick_o, // Sample tick
    input wire [3:0] tx_count_o, // Tx length
    input wire [3:0] rx_count_o, // Rx length
    input wire [5:0] frame_id_o // Identifier
);
    reg [11:0] gap_q;
    reg [11:0] div_q;
    reg armed_q;
    reg [7:0] wd_q;
    // Tick spacing tracker; disarmed on a divider change since the count may restart anywhere
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gap_q <= 12'h000;
            div_q <= 12'h000;
            armed_q <= 1'b0;
            wd_q <= 8'h00;
        end else begin
            gap_q <= sample_tick_o ? 12'h000 : gap_q + 12'h001;
            div_q <= baud_divisor_o;
            armed_q <= (enable_o && div_q == baud_divisor_o) ? (armed_q | sample_tick_o) : 1'b0;
            wd_q <= wdata_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    chk_tick_period: assert property (armed_q && enable_o && div_q == baud_divisor_o |->
        sample_tick_o == (gap_q == baud_divisor_o))
        else $error("sample tick spacing wrong");
    chk_spb_floor: assert property (samples_per_bit_o >= 6'h08)
        else $error("samples per bit below eight");
    chk_btr_write: assert property (wr_i && addr_i == `LUR_ADDR_BTR |=> resync_disable_o == wd_q[7] &&
        samples_per_bit_o == ((wd_q[5:0] < 6'h08) ? 6'h08 : wd_q[5:0]))
        else $error("bit timing write not applied");
    chk_div_low: assert property (wr_i && addr_i == `LUR_ADDR_BRRL |=> baud_divisor_o[7:0] == wd_q)
        else $error("divider low byte not applied");
    chk_div_high: assert property (wr_i && addr_i == `LUR_ADDR_BRRH |=> baud_divisor_o[11:8] == wd_q[3:0])
        else $error("divider high bits not applied");
    chk_uart_quiet: assert property (uart_mode_o |->
        tx_count_o == 4'h0 && rx_count_o == 4'h0 && frame_id_o == 6'h00)
        else $error("frame fields used in UART mode");
    chk_len_clamp: assert property (!uart_mode_o |-> tx_count_o <= 4'h8 && rx_count_o <= 4'h8)
        else $error("length above eight");
    chk_legacy_form: assert property (lin13_o && !uart_mode_o |->
        frame_id_o[5:4] == 2'b00 && tx_count_o inside {4'h2, 4'h4, 4'h8})
        else $error("legacy identifier form wrong");
    chk_irq_rsvd: assert property (rd_i && addr_i == `LUR_ADDR_IRQ_EN |=> rdata_o[7:4] == 4'h0)
        else $error("reserved enable bits not zero");
    chk_uart_send: assert property (wr_i && addr_i == `LUR_ADDR_DAT && uart_mode_o |=>
        uart_tx_start_o && tx_data_o == wd_q)
        else $error("UART data write not sent");
    cover property (sample_tick_o && armed_q);
    cover property (uart_tx_start_o);
    cover property (lin13_o && tx_count_o == 4'h4);
endmodule // lur_regs_monitor
bind lur_regs lur_regs_monitor lur_regs_monitor_i (.*);

// ===== bench/lur_regs_test.sv
// Self-checking bench for the LIN/UART register bank
`timescale 1ns/1ps
`include "lur_defines.vh"
module lur_regs_test;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o, tx_data_o, rx_data_i;
    logic busy_i, id_ok_evt_i, tx_ok_evt_i, rx_ok_evt_i, par_we_i, rx_we_i, uart_tx_start_o;
    logic lin13_o, uart_mode_o, enable_o, resync_disable_o, sample_tick_o, irq_o;
    logic [2:0] id_status_i, rx_idx_i, tx_idx_i, cmd_o;
    logic [6:0] err_evt_i;
    logic [1:0] par_i;
    logic [5:0] samples_per_bit_o, frame_id_o;
    logic [11:0] baud_divisor_o;
    logic [3:0] tx_count_o, rx_count_o;
    int n_errors = 0;
    int samples_checked = 0;
    int n;
    always #5 mclk_i = ~mclk_i;
    lur_regs lur_regs_i (.*);
    lur_ctl_model lur_ctl_model_i (.mclk_i(mclk_i), .busy_o(busy_i), .id_status_o(id_status_i),
        .err_evt_o(err_evt_i), .id_ok_o(id_ok_evt_i), .tx_ok_o(tx_ok_evt_i), .rx_ok_o(rx_ok_evt_i),
        .par_we_o(par_we_i), .par_o(par_i), .rx_we_o(rx_we_i), .rx_idx_o(rx_idx_i),
        .rx_data_o(rx_data_i), .tx_idx_o(tx_idx_i));
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One-cycle strobes; the trailing delay lets the edge's updates settle
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        {rd_i, addr_i} <= {1'b1, a};
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        cmp({4'h0, rdata_o}, {4'h0, e});
    endtask
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // A hang counts as a failure
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        for (int a = 0; a < 16; a++) if (a != 9) rdc(a[3:0], (a == 4) ? 8'h20 : 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(`LUR_ADDR_IRQ_EN, 8'h01 << k);
            lur_ctl_model_i.pulse((k == 3) ? 7'h01 : 7'h00, 3'h1 << k);
            cmp({11'h0, irq_o}, 12'h001);
            wr(`LUR_ADDR_IRQ_EN, 8'h0F ^ (8'h01 << k));
            cmp({11'h0, irq_o}, 12'h000);
            wr(`LUR_ADDR_STATUS, 8'h01 << k);
            wr(`LUR_ADDR_IRQ_EN, 8'h0F);
            cmp({11'h0, irq_o}, 12'h000);
        end
        for (int b = 0; b < 7; b++) begin
            lur_ctl_model_i.pulse(7'h01 << b, 3'h0);
            rdc(`LUR_ADDR_ERR, 8'h01 << b);
            wr(`LUR_ADDR_STATUS, 8'h08);
        end
        lur_ctl_model_i.pulse(7'h7F, 3'h0);
        wr(`LUR_ADDR_ERR, 8'h00);
        rdc(`LUR_ADDR_ERR, 8'h7F);
        rdc(`LUR_ADDR_STATUS, 8'h08);
        wr(`LUR_ADDR_STATUS, 8'h08);
        rdc(`LUR_ADDR_ERR, 8'h00);
        lur_ctl_model_i.state(1'b1, 3'h5, 3'h5);
        wr(`LUR_ADDR_CTRL, 8'h08);
        rdc(`LUR_ADDR_ERR, 8'h80);
        rdc(`LUR_ADDR_STATUS, 8'hB8);
        wr(`LUR_ADDR_STATUS, 8'h08);
        lur_ctl_model_i.state(1'b0, 3'h0, 3'h5);
        wr(`LUR_ADDR_BTR, 8'hC5);
        rdc(`LUR_ADDR_BTR, 8'h85);
        cmp({6'h0, samples_per_bit_o}, 12'h008);
        wr(`LUR_ADDR_BTR, 8'h3F);
        cmp({5'h0, resync_disable_o, samples_per_bit_o}, 12'h03F);
        wr(`LUR_ADDR_BRRL, 8'h03);
        wr(`LUR_ADDR_CTRL, 8'h09);
        cmp({8'h0, enable_o, cmd_o}, 12'h009);
        n = 0;
        repeat (40) begin
            @(posedge mclk_i);
            #1 n += sample_tick_o;
        end
        cmp(n[11:0], 12'h00A);
        wr(`LUR_ADDR_BRRH, 8'h0A);
        cmp(baud_divisor_o, 12'hA03);
        wr(`LUR_ADDR_DLR, 8'hF3);
        cmp({4'h0, tx_count_o, rx_count_o}, 12'h083);
        wr(`LUR_ADDR_DLR, 8'h29);
        cmp({4'h0, tx_count_o, rx_count_o}, 12'h028);
        wr(`LUR_ADDR_CTRL, 8'h40);
        cmp({10'h0, lin13_o, uart_mode_o}, 12'h002);
        for (int c = 0; c < 4; c++) begin
            wr(`LUR_ADDR_IDR, {2'b00, c[1:0], 4'hA});
            cmp({8'h0, tx_count_o}, (c < 2) ? 12'h002 : ((c == 2) ? 12'h004 : 12'h008));
            cmp({6'h0, frame_id_o}, 12'h00A);
        end
        wr(`LUR_ADDR_CTRL, 8'h00);
        wr(`LUR_ADDR_IDR, 8'hFF);
        cmp({2'h0, tx_count_o, frame_id_o}, 12'h0BF);
        rdc(`LUR_ADDR_IDR, 8'h3F);
        lur_ctl_model_i.parity(2'b10);
        rdc(`LUR_ADDR_IDR, 8'hBF);
        wr(`LUR_ADDR_SEL, 8'h00);
        for (int i = 1; i < 9; i++) wr(`LUR_ADDR_DAT, 8'h11 * i[7:0]);
        wr(`LUR_ADDR_SEL, 8'h06);
        rdc(`LUR_ADDR_DAT, 8'h77);
        rdc(`LUR_ADDR_DAT, 8'h88);
        rdc(`LUR_ADDR_DAT, 8'h11);
        wr(`LUR_ADDR_SEL, 8'h0B);
        rdc(`LUR_ADDR_DAT, 8'h44);
        rdc(`LUR_ADDR_DAT, 8'h44);
        lur_ctl_model_i.rx_byte(3'h3, 8'hA5);
        rdc(`LUR_ADDR_DAT, 8'hA5);
        cmp({4'h0, tx_data_o}, 12'h066);
        wr(`LUR_ADDR_CTRL, 8'h04);
        cmp({10'h0, lin13_o, uart_mode_o}, 12'h001);
        wr(`LUR_ADDR_DAT, 8'h5C);
        cmp({3'h0, uart_tx_start_o, tx_data_o}, 12'h15C);
        cmp({2'h0, tx_count_o, frame_id_o}, 12'h000);
        lur_ctl_model_i.rx_byte(3'h6, 8'h3C);
        rdc(`LUR_ADDR_DAT, 8'h3C);
        lur_ctl_model_i.pulse(7'h02, 3'h1);
        rdc(`LUR_ADDR_DAT, 8'h3C);
        rdc(`LUR_ADDR_STATUS, 8'h00);
        rdc(`LUR_ADDR_ERR, 8'h00);
        conclude();
    end
endmodule // lur_regs_test

// ===== include/lur_defines.vh
// Register offsets, field positions, reset values and timing for the LIN/UART register bank
`ifndef LUR_DEFINES_VH
`define LUR_DEFINES_VH

// Register offsets on the local register port
`define LUR_ADDR_CTRL 4'h0
`define LUR_ADDR_STATUS 4'h1
`define LUR_ADDR_IRQ_EN 4'h2
`define LUR_ADDR_ERR 4'h3
`define LUR_ADDR_BTR 4'h4
`define LUR_ADDR_BRRL 4'h5
`define LUR_ADDR_BRRH 4'h6
`define LUR_ADDR_DLR 4'h7
`define LUR_ADDR_IDR 4'h8
`define LUR_ADDR_SEL 4'h9
`define LUR_ADDR_DAT 4'hA

// Control register fields
`define LUR_CTRL_LIN13 6
`define LUR_CTRL_ENA 3
`define LUR_CTRL_UART 2
`define LUR_CMD_ABORT 3'h0

// Status register fields
`define LUR_ST_BUSY 4
`define LUR_ST_ERR 3
`define LUR_ST_IDOK 2
`define LUR_ST_TXOK 1
`define LUR_ST_RXOK 0

// Bit timing register fields
`define LUR_BTR_RESYNC_DIS 7
`define LUR_BTR_RESET 8'h20
`define LUR_SPB_RESET 6'h20
`define LUR_SPB_MIN 6'h08

// Buffer select field
`define LUR_SEL_NO_AINC 3

// Length handling
`define LUR_LEN_MAX 4'h8
`define LUR_LEN_2 4'h2
`define LUR_LEN_4 4'h4
`define LUR_LEN_8 4'h8

// Reset value for plain registers
`define LUR_ZERO8 8'h00

`endif

// ===== rtl/lur_regs.v
// LIN/UART controller register bank with response buffer and baud sample divider
// How it works
// - Enable register holds four interrupt enables.
// - Error bit 7 flags an abort command.
// - Error bits 6..0 flag detected faults.
// - Error flags clear only with summary clear.
// - Bit timing bit 7 disables resync.
// - Samples per bit reset 32, 8..63.
// - Sample period is divider plus one clocks.
// - Transmit length upper nibble, clamped to 8.
// - Receive length lower nibble, clamped to 8.
// - UART mode ignores length, id, select.
// - Legacy id bits 5:4 encode length.
// - Legacy id bits 3:0 are identifier.
// - New version uses six-bit identifier.
// - Id parity bits read-only, reset zero.
// - Select bit 3 stops index auto-increment.
// - Index selects buffer byte for data port.
// - Data port is buffer or single register.
// - Data port write outgoing, read incoming.
// - Summary error is OR of errors.
// - Flags interrupt when enabled, write-one clears.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "lur_defines.vh"

module lur_regs (
    // Clock and reset
    input wire mclk_i,                 // 100 MHz I/O clock
    input wire rst_b_i,                // Asynchronous reset, active low

    // Software register port
    input wire [3:0] addr_i,           // Register address
    input wire [7:0] wdata_i,          // Write data
    input wire wr_i,                   // Write strobe
    input wire rd_i,                   // Read strobe
    output wire [7:0] rdata_o,         // Read data, cycle after read strobe

    // Controller state and event pulses, all on this clock
    input wire busy_i,                 // Controller busy
    input wire [2:0] id_status_i,      // Identifier status from controller
    input wire [6:0] err_evt_i,        // Fault pulses, bit 6 timeout .. bit 0 bit error
    input wire id_ok_evt_i,            // Identifier event pulse
    input wire tx_ok_evt_i,            // Transmit done pulse
    input wire rx_ok_evt_i,            // Receive done pulse
    input wire par_we_i,               // Load identifier parity
    input wire [1:0] par_i,            // Computed identifier parity

    // Response buffer link to the frame engine
    input wire rx_we_i,                // Received byte strobe
    input wire [2:0] rx_idx_i,         // Buffer slot of received byte
    input wire [7:0] rx_data_i,        // Received byte
    input wire [2:0] tx_idx_i,         // Buffer slot the transmitter reads
    output reg [7:0] tx_data_o,        // Byte at tx_idx_i, or UART outgoing byte
    output reg uart_tx_start_o,        // Pulse on UART data port write

    // Configuration towards the frame engine
    output wire lin13_o,               // Legacy protocol version selected
    output wire uart_mode_o,           // UART mode selected
    output wire enable_o,              // Controller enabled
    output wire [2:0] cmd_o,           // Command field
    output wire resync_disable_o,      // Bit resynchronisation disabled
    output wire [5:0] samples_per_bit_o, // Samples per bit, at least 8
    output wire [11:0] baud_divisor_o, // Baud divider value
    output reg sample_tick_o,          // One pulse per sample period
    output wire [3:0] tx_count_o,      // Response bytes to transmit
    output wire [3:0] rx_count_o,      // Response bytes to receive
    output wire [5:0] frame_id_o,      // Frame identifier
    output wire irq_o                  // Combined enabled status flags
);

    // Clamp a length nibble to the buffer size
    function [3:0] clamp8;
        input [3:0] len;
        begin
            clamp8 = (len > `LUR_LEN_MAX) ? `LUR_LEN_MAX : len;
        end
    endfunction

    // Address match against one register offset; used by strobes and index logic
    function reg_hit;
        input [3:0] addr;
        input [3:0] offset;
        begin
            reg_hit = (addr == offset);
        end
    endfunction

    // Reset synchroniser stages
    reg rst_s1_q;
    reg rst_n_q;

    // Software-visible registers and their next values
    reg [7:0] ctrl_q;
    reg [2:0] st_q;                    // id_ok, tx_ok, rx_ok
    reg [3:0] irq_en_q;
    reg [7:0] err_q;
    wire [7:0] err_d;
    reg resync_dis_q;
    reg [5:0] spb_q;
    reg [11:0] div_q;
    reg [7:0] dlr_q;
    reg [5:0] idr_q;
    reg [1:0] par_q;
    reg no_ainc_q;
    reg [2:0] idx_q;

    // Received byte for UART mode and the response buffer for LIN mode;
    // eight slots cover the longest response, so the index simply wraps
    reg [7:0] uart_rx_q;
    reg [7:0] buf_q [0:7];

    // Read path, divider count and decode helpers
    reg [7:0] rdata_q;
    reg [7:0] rd_mux;
    reg [11:0] div_cnt_q;
    reg [3:0] leg_len;
    reg [2:0] st_d;

    // Strobe decodes for registers with side effects
    wire wr_ctrl = wr_i & reg_hit(addr_i, `LUR_ADDR_CTRL);
    wire wr_st = wr_i & reg_hit(addr_i, `LUR_ADDR_STATUS);
    wire wr_sel = wr_i & reg_hit(addr_i, `LUR_ADDR_SEL);
    wire wr_dat = wr_i & reg_hit(addr_i, `LUR_ADDR_DAT);
    wire rd_dat = rd_i & reg_hit(addr_i, `LUR_ADDR_DAT);

    // Mode bits; UART mode takes precedence over the protocol version bit in the length and identifier outputs
    wire uart = ctrl_q[`LUR_CTRL_UART];
    wire lin13 = ctrl_q[`LUR_CTRL_LIN13];

    // Summary error and the four interrupt-capable flags
    wire err_sum = |err_q;
    wire [3:0] flags = {err_sum, st_q};

    // Abort taken from a command write that carries enable and the abort code
    // It only counts while a frame is in progress; an idle abort still writes the control register but sets no error flag
    wire abort_evt = wr_ctrl & wdata_i[`LUR_CTRL_ENA] & ~wdata_i[`LUR_CTRL_UART]
                     & (wdata_i[2:0] == `LUR_CMD_ABORT) & busy_i;

    // Summary clear by write-one, or by a UART data read
    wire err_clr = (wr_st & wdata_i[`LUR_ST_ERR]) | (uart & rd_dat);
    // Index advances only in LIN mode; UART mode ignores the buffer fields
    wire dat_access = (wr_dat | rd_dat) & ~uart;

    // Loop variable for the buffer reset
    integer i;

    // Reset release through two flops; assertion stays asynchronous
    // All other flops reset from the released copy, so none leaves reset on a skewed edge
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Fault sources in flag order: abort on top, line faults below
    wire [7:0] err_set = {abort_evt, err_evt_i};

    // Error flags, one per bit. A fault in the cycle of a clear survives the clear,
    // so software never loses an error that arrives while it is clearing.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_err_flag
            assign err_d[g] = err_set[g] | (err_q[g] & ~err_clr);
        end
    endgenerate

    // Status flags: write-one clears, set wins; UART data access also clears
    // Only the event flags live here; the summary error derives from the error flags
    always @* begin
        st_d = st_q;
        if (wr_st) begin
            st_d = st_d & ~wdata_i[2:0];
        end
        if (uart & wr_dat) begin
            st_d[`LUR_ST_TXOK] = 1'b0;
        end
        if (uart & rd_dat) begin
            st_d[`LUR_ST_RXOK] = 1'b0;
        end
        st_d = st_d | {id_ok_evt_i, tx_ok_evt_i, rx_ok_evt_i};
    end

    // Software registers and event flags
    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= `LUR_ZERO8;
            st_q <= 3'h0;
            irq_en_q <= 4'h0;
            err_q <= `LUR_ZERO8;
            resync_dis_q <= 1'b0;
            spb_q <= `LUR_SPB_RESET;
            div_q <= 12'h000;
            dlr_q <= `LUR_ZERO8;
            idr_q <= 6'h00;
            par_q <= 2'h0;
            no_ainc_q <= 1'b0;
            uart_tx_start_o <= 1'b0;
        end else begin
            err_q <= err_d;
            st_q <= st_d;
            uart_tx_start_o <= uart & wr_dat;
            // Parity comes from the frame engine; software cannot write it
            if (par_we_i) begin
                par_q <= par_i;
            end
            if (wr_i) begin
                case (addr_i)
                    `LUR_ADDR_CTRL: begin
                        ctrl_q <= wdata_i;
                    end
                    `LUR_ADDR_IRQ_EN: begin
                        irq_en_q <= wdata_i[3:0];
                    end
                    `LUR_ADDR_BTR: begin
                        resync_dis_q <= wdata_i[`LUR_BTR_RESYNC_DIS];
                        spb_q <= wdata_i[5:0];
                    end
                    `LUR_ADDR_BRRL: begin
                        div_q[7:0] <= wdata_i;
                    end
                    `LUR_ADDR_BRRH: begin
                        div_q[11:8] <= wdata_i[3:0];
                    end
                    `LUR_ADDR_DLR: begin
                        dlr_q <= wdata_i;
                    end
                    `LUR_ADDR_IDR: begin
                        idr_q <= wdata_i[5:0];
                    end
                    `LUR_ADDR_SEL: begin
                        no_ainc_q <= wdata_i[`LUR_SEL_NO_AINC];
                    end
                    default: begin
                        // Error, status and unmapped offsets hold no stored field here
                    end
                endcase
            end
        end
    end

    // Buffer index: set by select write, advanced by data port access.
    // A select write and a data access never share a cycle, as strobes are exclusive.
    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            idx_q <= 3'h0;
        end else if (wr_sel) begin
            idx_q <= wdata_i[2:0];
        end else if (dat_access & ~no_ainc_q) begin
            idx_q <= idx_q + 3'h1;
        end
    end

    // Response buffer: software writes first, the receiver fills slots too.
    // A receive strobe on the slot software writes in that cycle wins, as bus data is newer.
    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (i = 0; i < 8; i = i + 1) begin
                buf_q[i] <= `LUR_ZERO8;
            end
            uart_rx_q <= `LUR_ZERO8;
        end else begin
            if (wr_dat & ~uart) begin
                buf_q[idx_q] <= wdata_i;
            end
            if (rx_we_i & ~uart) begin
                buf_q[rx_idx_i] <= rx_data_i;
            end
            if (rx_we_i & uart) begin
                uart_rx_q <= rx_data_i;
            end
        end
    end

    // Outgoing byte: buffer slot in LIN mode, last written byte in UART mode
    // The LIN copy lags tx_idx_i by one cycle; the frame engine allows for that
    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_data_o <= `LUR_ZERO8;
        end else if (uart) begin
            if (wr_dat) begin
                tx_data_o <= wdata_i;
            end
        end else begin
            tx_data_o <= buf_q[tx_idx_i];
        end
    end

    // Sample divider: a tick every div+1 clocks, held idle while disabled.
    // The compare is >= so a smaller divisor written mid-count restarts at once
    // instead of running the counter round through its full range.
    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_cnt_q <= 12'h000;
            sample_tick_o <= 1'b0;
        end else if (!ctrl_q[`LUR_CTRL_ENA]) begin
            div_cnt_q <= 12'h000;
            sample_tick_o <= 1'b0;
        end else if (div_cnt_q >= div_q) begin
            div_cnt_q <= 12'h000;
            sample_tick_o <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 12'h001;
            sample_tick_o <= 1'b0;
        end
    end

    // Legacy length code decode
    // Codes 00 and 01 both mean two bytes, so only the upper codes are listed
    always @* begin
        case (idr_q[5:4])
            2'b10: leg_len = `LUR_LEN_4;
            2'b11: leg_len = `LUR_LEN_8;
            default: leg_len = `LUR_LEN_2;
        endcase
    end

    // Read multiplexer; reserved bits read zero
    // Status bits 7:4 are live levels from the engine, not stored copies
    always @* begin
        case (addr_i)
            `LUR_ADDR_CTRL: rd_mux = ctrl_q;
            `LUR_ADDR_STATUS: rd_mux = {id_status_i, busy_i, flags};
            `LUR_ADDR_IRQ_EN: rd_mux = {4'h0, irq_en_q};
            `LUR_ADDR_ERR: rd_mux = err_q;
            `LUR_ADDR_BTR: rd_mux = {resync_dis_q, 1'b0, spb_q};
            `LUR_ADDR_BRRL: rd_mux = div_q[7:0];
            `LUR_ADDR_BRRH: rd_mux = {4'h0, div_q[11:8]};
            `LUR_ADDR_DLR: rd_mux = dlr_q;
            `LUR_ADDR_IDR: rd_mux = {par_q, idr_q};
            `LUR_ADDR_SEL: rd_mux = {4'h0, no_ainc_q, idx_q};
            `LUR_ADDR_DAT: rd_mux = uart ? uart_rx_q : buf_q[idx_q];
            default: rd_mux = `LUR_ZERO8;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    // Returning zero otherwise keeps a stale byte from looking like a fresh read.
    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= `LUR_ZERO8;
        end else if (rd_i) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= `LUR_ZERO8;
        end
    end

    // Read data and the masked interrupt request
    assign rdata_o = rdata_q;
    assign irq_o = |(flags & irq_en_q);

    // Configuration fields straight from the registers
    assign lin13_o = lin13;
    assign uart_mode_o = uart;
    assign enable_o = ctrl_q[`LUR_CTRL_ENA];
    assign cmd_o = ctrl_q[2:0];
    assign resync_disable_o = resync_dis_q;
    // Values below the usable minimum are raised to it
    assign samples_per_bit_o = (spb_q < `LUR_SPB_MIN) ? `LUR_SPB_MIN : spb_q;
    assign baud_divisor_o = div_q;
    // Lengths matter only in LIN mode; legacy version takes length from the id
    // The clamp keeps a count above eight from running past the buffer
    assign tx_count_o = uart ? 4'h0 : (lin13 ? leg_len : clamp8(dlr_q[7:4]));
    assign rx_count_o = uart ? 4'h0 : (lin13 ? leg_len : clamp8(dlr_q[3:0]));
    // The legacy identifier is four bits; the register's upper two bits carry the length
    assign frame_id_o = uart ? 6'h00 : (lin13 ? {2'b00, idr_q[3:0]} : idr_q);

endmodule // lur_regs
